// ---- tfc_channel.sv ----
// Purpose: One compare/capture channel: input select, edge detect, output
// Assumes: Inputs synchronous to clk
// Notes:   Capture value storage lies outside this block
`timescale 1ns/10ps
module tfc_channel
   import tfc_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire tfc_ctrl_t  ctrl,
   input  wire logic       pin_in,
   input  wire logic [7:0] route_in,
   input  wire tfc_tev_t   tev,
   output logic            edge_out,
   output logic            cap_event,
   output logic            out_level
);

   logic       src;
   logic       src_d_reg;
   logic       input_filter_enable_a_reg;
   logic       input_filter_enable_b_reg;
   logic       input_filter_enable_reg;
   logic       rise;
   logic       fall;
   logic       det;
   logic       alt_reg;
   logic       out_reg;

   // ----------------------------------------------------------------
   // Input source and filter
   // ----------------------------------------------------------------
   // Pin or routed event channel
   assign src = ctrl.input_source_select ? route_in[ctrl.routing_channel_selector]
                                         : pin_in;

   // Three-sample agreement filter
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         input_filter_enable_a_reg <= 1'b0;
         input_filter_enable_b_reg <= 1'b0;
         input_filter_enable_reg   <= 1'b0;
      end else begin
         input_filter_enable_a_reg <= src;
         input_filter_enable_b_reg <= input_filter_enable_a_reg;
         if (input_filter_enable_a_reg == input_filter_enable_b_reg && src == input_filter_enable_a_reg) begin
            input_filter_enable_reg <= src;
         end
      end
   end

   // Previous sample for edge detection
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         src_d_reg <= 1'b0;
      end else begin
         src_d_reg <= ctrl.input_filter_enable ? input_filter_enable_reg : src;
      end
   end

   // ----------------------------------------------------------------
   // Edge detector
   // ----------------------------------------------------------------
   assign rise = (ctrl.input_filter_enable ? input_filter_enable_reg : src) & ~src_d_reg;
   assign fall = ~(ctrl.input_filter_enable ? input_filter_enable_reg : src) & src_d_reg;

   // Edge select, or plain level for none
   always_comb begin
      unique case (ctrl.capture_edge_select)
         TFC_EDGE_RISE: det = rise;
         TFC_EDGE_FALL: det = fall;
         TFC_EDGE_BOTH: det = rise | fall;
         TFC_EDGE_NONE: det = ctrl.input_filter_enable ? input_filter_enable_reg : src;
      endcase
   end

   // Detector drives capture and external clock
   assign edge_out = det;

   // ----------------------------------------------------------------
   // Capture event qualification
   // ----------------------------------------------------------------
   // Alternate-capture phase toggles on each capture
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         alt_reg <= 1'b0;
      end else if (ctrl.mode != TFC_MODE_CAPTURE) begin
         alt_reg <= 1'b0;
      end else if (det) begin
         alt_reg <= ~alt_reg;
      end
   end

   always_comb begin
      cap_event = 1'b0;
      if (ctrl.mode == TFC_MODE_CAPTURE && det) begin
         unique case (ctrl.capture_event_qualifier)
            TFC_QUAL_EVERY: cap_event = 1'b1;
            TFC_QUAL_ALT:   cap_event = alt_reg;
            TFC_QUAL_RISE:  cap_event = (ctrl.capture_edge_select == TFC_EDGE_BOTH)
                                        ? rise : 1'b1;
            TFC_QUAL_FALL:  cap_event = (ctrl.capture_edge_select == TFC_EDGE_BOTH)
                                        ? fall : 1'b1;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Output actions
   // ----------------------------------------------------------------
   function automatic logic apply(input tfc_act_t a, input logic v);
      unique case (a)
         TFC_ACT_NONE:   apply = v;
         TFC_ACT_TOGGLE: apply = ~v;
         TFC_ACT_CLEAR:  apply = 1'b0;
         TFC_ACT_SET:    apply = 1'b1;
      endcase
   endfunction : apply

   // Underflow, overflow then match, later wins
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         out_reg <= 1'b0;
      end else if (ctrl.mode == TFC_MODE_OFF || ctrl.mode == TFC_MODE_CAPTURE) begin
         out_reg <= ctrl.initial_state;
      end else begin
         out_reg <= apply(tev.match ? ctrl.match_output_action : TFC_ACT_NONE,
                    apply(tev.overflow ? ctrl.overflow_output_action : TFC_ACT_NONE,
                    apply(tev.underflow ? ctrl.underflow_output_action : TFC_ACT_NONE,
                          out_reg)));
      end
   end

   assign out_level = out_reg ^ ctrl.output_invert;

endmodule : tfc_channel

// ---- tfc_pin_model.sv ----
// Purpose: Far side of the timer channels: pin wires and routing lines
// Assumes: Bench sets the external levels after a rising edge
// Notes:   Wire level is resolved from the device's output enables
`timescale 1ns/10ps
module tfc_pin_model (
   input  wire logic [2:0] pin_out,
   input  wire logic [2:0] pin_oe_n,
   input  wire logic [2:0] ext_level,
   input  wire logic [7:0] route_level,
   output logic [2:0]      pin_in,
   output logic [7:0]      event_routing_channel
);
   // ----------------------------------------------------------------
   // Wire resolution
   // ----------------------------------------------------------------
   // Device wins the wire while it drives it
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         pin_in[i] = pin_oe_n[i] ? ext_level[i] : pin_out[i];
      end
   end
   // Routing lines are plain levels
   assign event_routing_channel = route_level;
endmodule : tfc_pin_model

// ---- tfc_pkg.sv ----
// Purpose: Constants and types for the timer flag and channel control block
// Assumes: APB register access, 32-bit data
// Notes:   Offsets are byte addresses
package tfc_pkg;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [11:0] TFC_OFS_FLAGS     = 12'h010;
   localparam logic [11:0] TFC_OFS_FLAG_SET  = 12'h014;
   localparam logic [11:0] TFC_OFS_FLAG_CLR  = 12'h018;
   localparam logic [11:0] TFC_OFS_LIMIT     = 12'h01C;
   localparam logic [11:0] TFC_OFS_LIMIT_BUF = 12'h020;
   localparam logic [11:0] TFC_OFS_COUNT     = 12'h024;
   localparam logic [11:0] TFC_OFS_ROUTE     = 12'h028;
   localparam logic [11:0] TFC_OFS_CH_CTRL   = 12'h030;
   localparam logic [11:0] TFC_OFS_CH_STRIDE = 12'h010;
   localparam logic [11:0] TFC_OFS_STATUS    = 12'h008;

   // ----------------------------------------------------------------
   // Field positions and masks
   // ----------------------------------------------------------------
   localparam int TFC_BIT_OVF      = 0;
   localparam int TFC_BIT_UNF      = 1;
   localparam int TFC_BIT_EVT0     = 4;
   localparam int TFC_BIT_OVR0     = 8;
   localparam int TFC_BIT_LBV      = 2;
   localparam logic [31:0] TFC_FLAG_MASK  = 32'h0000_0773;
   localparam logic [31:0] TFC_ROUTE_MASK = 32'h0003_0007;
   localparam logic [31:0] TFC_CTRL_MASK  = 32'h0F37_3F17;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [15:0] TFC_LIMIT_RST  = 16'hFFFF;
   localparam logic [15:0] TFC_ZERO16     = 16'h0000;

   // ----------------------------------------------------------------
   // Encodings
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      TFC_EDGE_RISE = 2'b00, TFC_EDGE_FALL = 2'b01,
      TFC_EDGE_BOTH = 2'b10, TFC_EDGE_NONE = 2'b11
   } tfc_edge_t;

   typedef enum logic [1:0] {
      TFC_QUAL_EVERY = 2'b00, TFC_QUAL_ALT  = 2'b01,
      TFC_QUAL_RISE  = 2'b10, TFC_QUAL_FALL = 2'b11
   } tfc_qual_t;

   typedef enum logic [1:0] {
      TFC_ACT_NONE = 2'b00, TFC_ACT_TOGGLE = 2'b01,
      TFC_ACT_CLEAR = 2'b10, TFC_ACT_SET = 2'b11
   } tfc_act_t;

   typedef enum logic [1:0] {
      TFC_MODE_OFF = 2'b00, TFC_MODE_CAPTURE = 2'b01,
      TFC_MODE_COMPARE = 2'b10, TFC_MODE_PWM = 2'b11
   } tfc_mode_t;

   // Channel control fields
   typedef struct packed {
      logic [3:0] rsv_31_28;
      tfc_qual_t  capture_event_qualifier;
      tfc_edge_t  capture_edge_select;
      logic [1:0] rsv_23_22;
      logic       input_filter_enable;
      logic       input_source_select;
      logic       rsv_19;
      logic [2:0] routing_channel_selector;
      logic [1:0] rsv_15_14;
      tfc_act_t   underflow_output_action;
      tfc_act_t   overflow_output_action;
      tfc_act_t   match_output_action;
      logic [2:0] rsv_7_5;
      logic       initial_state;
      logic       rsv_3;
      logic       output_invert;
      tfc_mode_t  mode;
   } tfc_ctrl_t;

   // Timer events seen by one channel
   typedef struct packed {
      logic overflow;
      logic underflow;
      logic match;
   } tfc_tev_t;

endpackage : tfc_pkg

// ---- tfc_regs.sv ----
// Purpose: Flag, limit, counter, routing and channel control registers
// Assumes: APB slave, zero wait states, inputs synchronous to clk
// Notes:   Counter sequencing itself lies outside; it feeds events in
//
// What this block does
// - Writing one to underflow or overflow set bit sets that flag.
// - Clear-register bits 10..8 clear capture overrun flags of channels 2..0.
// - Clear-register bits 6..4 clear channel event flags of channels 2..0.
// - Clear-register bit 1 clears underflow, bit 0 clears overflow.
// - Counter limit is 16 bits, resets to all ones, hardware may update.
// - A valid limit buffer is copied into the limit at the update event.
// - A channel reaches its pin only while its pin-enable bit is set.
// - Qualifier 0 signals every capture; qualifier 1 every second capture.
// - Qualifier 2 or 3 with both edges signals only rising or falling.
// - Edge select 0, 1, 2 detects rising, falling or both edges.
// - Edge select 3 passes the channel input through unchanged.
// - Detector output feeds input capture and the external clock input.
// - Input select 0 takes the pin, 1 the chosen routing channel.
// - Three-bit selector picks one of eight routing channels.
// - Underflow action 0..3: keep, toggle, clear, set the output.
// - Overflow action 0..3: keep, toggle, clear, set the output.
// - Match action 0..3: keep, toggle, clear, set the output.
// - Channel mode selects off, capture, compare or PWM.
`timescale 1ns/10ps
module tfc_regs
   import tfc_pkg::*;
#(
   parameter int NCH = 3
)(
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [11:0]      paddr,
   input  wire logic [31:0]      pwdata,
   output logic [31:0]           prdata,
   output logic                  pready,
   output logic                  pslverr,
   input  wire logic             hw_overflow,
   input  wire logic             hw_underflow,
   input  wire logic             hw_update,
   input  wire logic             hw_count_load,
   input  wire logic [15:0]      hw_count_value,
   input  wire logic [NCH-1:0]   hw_match,
   input  wire logic [NCH-1:0]   hw_capture_overrun,
   input  wire logic [NCH-1:0]   pin_in,
   input  wire logic [7:0]       event_routing_channel,
   output logic [NCH-1:0]        pin_out,
   output logic [NCH-1:0]        pin_oe_n,
   output logic [NCH-1:0]        capture_strobe,
   output logic [NCH-1:0]        ext_clock_in,
   output logic [31:0]           flags,
   output logic [15:0]           counter_limit
);

   logic [31:0]     flags_reg;
   logic [31:0]     flags_next;
   logic [15:0]     limit_reg;
   logic [15:0]     limit_buf_reg;
   logic            limit_buf_valid_reg;
   logic [15:0]     count_reg;
   logic [31:0]     route_reg;
   tfc_ctrl_t       ctrl_reg [NCH];
   logic [31:0]     rdata;
   logic            wr_en;
   logic            rd_en;
   logic [NCH-1:0]  ch_edge;
   logic [NCH-1:0]  ch_evt;
   logic [NCH-1:0]  ch_out;
   logic [NCH-1:0]  pin_out_reg;
   logic [NCH-1:0]  pin_oe_n_reg;
   logic [NCH-1:0]  cap_reg;
   logic [NCH-1:0]  eclk_reg;
   logic [31:0]     hw_set;

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   assign wr_en   = psel & penable & pwrite;
   assign rd_en   = psel & ~penable & ~pwrite;
   assign pready  = 1'b1;
   assign pslverr = 1'b0;

   // ----------------------------------------------------------------
   // Interrupt flags
   // ----------------------------------------------------------------
   always_comb begin
      hw_set = 32'h0000_0000;
      hw_set[TFC_BIT_OVF] = hw_overflow;
      hw_set[TFC_BIT_UNF] = hw_underflow;
      for (int i = 0; i < NCH; i++) begin
         hw_set[TFC_BIT_EVT0 + i] = ch_evt[i] | hw_match[i];
         hw_set[TFC_BIT_OVR0 + i] = hw_capture_overrun[i];
      end
   end

   // Clear first, then hardware and software sets win
   always_comb begin
      flags_next = flags_reg;
      if (wr_en && paddr == TFC_OFS_FLAG_CLR) begin
         flags_next = flags_next & ~(pwdata & TFC_FLAG_MASK);
      end
      if (wr_en && paddr == TFC_OFS_FLAG_SET) begin
         flags_next = flags_next | (pwdata & TFC_FLAG_MASK);
      end
      flags_next = flags_next | (hw_set & TFC_FLAG_MASK);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         flags_reg <= 32'h0000_0000;
      end else begin
         flags_reg <= flags_next;
      end
   end

   // ----------------------------------------------------------------
   // Limit, limit buffer and counter value
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         limit_reg           <= TFC_LIMIT_RST;
         limit_buf_reg       <= TFC_ZERO16;
         limit_buf_valid_reg <= 1'b0;
      end else begin
         if (wr_en && paddr == TFC_OFS_LIMIT) begin
            limit_reg           <= pwdata[15:0];
            limit_buf_valid_reg <= 1'b0;
         end else if (hw_update && limit_buf_valid_reg) begin
            limit_reg           <= limit_buf_reg;
            limit_buf_valid_reg <= 1'b0;
         end
         if (wr_en && paddr == TFC_OFS_LIMIT_BUF) begin
            limit_buf_reg       <= pwdata[15:0];
            limit_buf_valid_reg <= 1'b1;
         end
      end
   end

   // Software write wins over hardware load
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         count_reg <= TFC_ZERO16;
      end else if (wr_en && paddr == TFC_OFS_COUNT) begin
         count_reg <= pwdata[15:0];
      end else if (hw_count_load) begin
         count_reg <= hw_count_value;
      end
   end

   // ----------------------------------------------------------------
   // Routing and channel control
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         route_reg <= 32'h0000_0000;
      end else if (wr_en && paddr == TFC_OFS_ROUTE) begin
         route_reg <= pwdata & TFC_ROUTE_MASK;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < NCH; i++) begin
            ctrl_reg[i] <= tfc_ctrl_t'(32'h0000_0000);
         end
      end else begin
         for (int i = 0; i < NCH; i++) begin
            if (wr_en && paddr == TFC_OFS_CH_CTRL + 12'(i) * TFC_OFS_CH_STRIDE) begin
               ctrl_reg[i] <= tfc_ctrl_t'(pwdata & TFC_CTRL_MASK);
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Channels
   // ----------------------------------------------------------------
   for (genvar g = 0; g < NCH; g++) begin : g_ch
      tfc_channel u_ch (
         .clk       (clk),
         .rst       (rst),
         .ctrl      (ctrl_reg[g]),
         .pin_in    (pin_in[g] & route_reg[g]),
         .route_in  (event_routing_channel),
         .tev       ({hw_overflow, hw_underflow, hw_match[g]}),
         .edge_out  (ch_edge[g]),
         .cap_event (ch_evt[g]),
         .out_level (ch_out[g])
      );
   end

   // Registered pin drive, enabled only for output modes
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_out_reg  <= '0;
         pin_oe_n_reg <= '1;
         cap_reg      <= '0;
         eclk_reg     <= '0;
      end else begin
         pin_out_reg <= ch_out;
         cap_reg     <= ch_evt;
         eclk_reg    <= ch_edge;
         for (int i = 0; i < NCH; i++) begin
            pin_oe_n_reg[i] <= ~(route_reg[i] & ctrl_reg[i].mode[1]);
         end
      end
   end

   assign pin_out        = pin_out_reg;
   assign pin_oe_n       = pin_oe_n_reg;
   assign capture_strobe = cap_reg;
   assign ext_clock_in   = eclk_reg;
   assign flags          = flags_reg;
   assign counter_limit  = limit_reg;

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   always_comb begin
      rdata = 32'h0000_0000;
      if (paddr == TFC_OFS_FLAGS) begin
         rdata = flags_reg;
      end else if (paddr == TFC_OFS_LIMIT) begin
         rdata = {16'h0000, limit_reg};
      end else if (paddr == TFC_OFS_LIMIT_BUF) begin
         rdata = {16'h0000, limit_buf_reg};
      end else if (paddr == TFC_OFS_COUNT) begin
         rdata = {16'h0000, count_reg};
      end else if (paddr == TFC_OFS_ROUTE) begin
         rdata = route_reg;
      end else if (paddr == TFC_OFS_STATUS) begin
         rdata[TFC_BIT_LBV] = limit_buf_valid_reg;
      end
      for (int i = 0; i < NCH; i++) begin
         if (paddr == TFC_OFS_CH_CTRL + 12'(i) * TFC_OFS_CH_STRIDE) begin
            rdata = 32'(ctrl_reg[i]);
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prdata <= 32'h0000_0000;
      end else if (rd_en) begin
         prdata <= rdata;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_set_flag;
      @(posedge clk) disable iff (rst)
      wr_en && paddr == TFC_OFS_FLAG_SET && pwdata[TFC_BIT_UNF] |=> flags_reg[TFC_BIT_UNF];
   endproperty
   a_set_flag: assert property (p_set_flag) else $error("set write lost");

   property p_clr_ovr;
      @(posedge clk) disable iff (rst)
      wr_en && paddr == TFC_OFS_FLAG_CLR && pwdata[10] && !hw_capture_overrun[2]
      |=> !flags_reg[10];
   endproperty
   a_clr_ovr: assert property (p_clr_ovr) else $error("overrun flag not cleared");

   property p_clr_evt;
      @(posedge clk) disable iff (rst)
      wr_en && paddr == TFC_OFS_FLAG_CLR && pwdata[4] && !hw_set[4] |=> !flags_reg[4];
   endproperty
   a_clr_evt: assert property (p_clr_evt) else $error("event flag not cleared");

   property p_clr_ovf;
      @(posedge clk) disable iff (rst)
      wr_en && paddr == TFC_OFS_FLAG_CLR && pwdata[0] && !hw_overflow |=> !flags_reg[0];
   endproperty
   a_clr_ovf: assert property (p_clr_ovf) else $error("overflow flag not cleared");

   property p_zero_keep;
      @(posedge clk) disable iff (rst)
      wr_en && paddr == TFC_OFS_FLAG_CLR && !pwdata[1] && flags_reg[1] |=> flags_reg[1];
   endproperty
   a_zero_keep: assert property (p_zero_keep) else $error("zero bit changed flag");

   property p_limit_load;
      @(posedge clk) disable iff (rst)
      hw_update && limit_buf_valid_reg && !(wr_en && paddr == TFC_OFS_LIMIT)
      |=> limit_reg == $past(limit_buf_reg) && !limit_buf_valid_reg
          || $past(wr_en && paddr == TFC_OFS_LIMIT_BUF);
   endproperty
   a_limit_load: assert property (p_limit_load) else $error("limit not loaded");

   property p_pin_off;
      @(posedge clk) disable iff (rst)
      !route_reg[0] |=> pin_oe_n[0];
   endproperty
   a_pin_off: assert property (p_pin_off) else $error("pin driven while disabled");

   property p_off_quiet;
      @(posedge clk) disable iff (rst)
      ctrl_reg[0].mode == TFC_MODE_OFF |=> !capture_strobe[0];
   endproperty
   a_off_quiet: assert property (p_off_quiet) else $error("capture while off");

   c_set:    cover property (@(posedge clk) wr_en && paddr == TFC_OFS_FLAG_SET);
   c_reload: cover property (@(posedge clk) hw_update && limit_buf_valid_reg);
   c_cap:    cover property (@(posedge clk) capture_strobe[1]);

endmodule : tfc_regs

// ---- tfc_regs_tb_top.sv ----
// Purpose: Self-checking bench for the flag and channel control registers
// Assumes: Zero-wait APB slave, one clock
// Notes:   Capture strobes on channel 1 are counted over fixed windows
`timescale 1ns/10ps
module tfc_regs_tb_top;
   import tfc_pkg::*;
   logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, flags, rd;
   logic pready, pslverr, hw_overflow = 0, hw_underflow = 0, hw_update = 0;
   logic hw_count_load = 0;
   logic [15:0] hw_count_value = 16'h0000, counter_limit;
   logic [2:0] hw_match = 0, hw_capture_overrun = 0, pin_in, pin_out, pin_oe_n;
   logic [2:0] capture_strobe, ext_clock_in, ext_level = 0;
   logic [7:0] event_routing_channel, route_level = 8'h00;
   int fails = 0, checks = 0, strobes = 0, cycles = 0;
   // ----------------------------------------------------------------
   // Clock, timeout, strobe counter
   // ----------------------------------------------------------------
   always #5 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (capture_strobe[1] === 1'b1) strobes++;
      if (cycles == 20000) begin
         fails++;
         final_report();
      end
   end
   tfc_regs tfc_regs_inst (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .hw_overflow(hw_overflow),
      .hw_underflow(hw_underflow), .hw_update(hw_update), .hw_count_load(hw_count_load),
      .hw_count_value(hw_count_value), .hw_match(hw_match),
      .hw_capture_overrun(hw_capture_overrun), .pin_in(pin_in),
      .event_routing_channel(event_routing_channel), .pin_out(pin_out),
      .pin_oe_n(pin_oe_n), .capture_strobe(capture_strobe),
      .ext_clock_in(ext_clock_in), .flags(flags), .counter_limit(counter_limit));
   tfc_pin_model tfc_pin_model_inst (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
      .ext_level(ext_level), .route_level(route_level), .pin_in(pin_in),
      .event_routing_channel(event_routing_channel));
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // One APB transfer, setup then access until pready
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask : rd_chk
   // Program channel 1, send pulses on pin or routing line 5, count strobes
   task automatic cap(input logic [31:0] c, input int np, input int exp);
      apb(1'b1, TFC_OFS_CH_CTRL + TFC_OFS_CH_STRIDE, c);
      repeat (6) @(posedge clk);
      strobes = 0;
      repeat (np) begin
         if (c[20]) route_level[5] <= 1'b1; else ext_level[1] <= 1'b1;
         repeat (8) @(posedge clk);
         route_level[5] <= 1'b0;
         ext_level[1] <= 1'b0;
         repeat (8) @(posedge clk);
      end
      chk(strobes, exp);
   endtask : cap
   task automatic final_report();
      if (fails == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : final_report
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd_chk(TFC_OFS_FLAGS, 32'h0);
      rd_chk(TFC_OFS_LIMIT, 32'h0000_FFFF);
      rd_chk(TFC_OFS_LIMIT_BUF, 32'h0);
      rd_chk(TFC_OFS_COUNT, 32'h0);
      rd_chk(12'h100, 32'h0);
      apb(1'b1, TFC_OFS_FLAG_SET, 32'h3);
      rd_chk(TFC_OFS_FLAGS, 32'h3);
      apb(1'b1, TFC_OFS_FLAG_SET, 32'h770);
      apb(1'b1, TFC_OFS_FLAG_CLR, 32'h0);
      rd_chk(TFC_OFS_FLAGS, 32'h773);
      apb(1'b1, TFC_OFS_FLAG_CLR, 32'h1);
      rd_chk(TFC_OFS_FLAGS, 32'h772);
      apb(1'b1, TFC_OFS_FLAG_CLR, 32'h500);
      rd_chk(TFC_OFS_FLAGS, 32'h272);
      apb(1'b1, TFC_OFS_FLAG_CLR, 32'h250);
      rd_chk(TFC_OFS_FLAGS, 32'h22);
      apb(1'b1, TFC_OFS_FLAG_CLR, 32'h22);
      chk(flags, 32'h0);
      // Limit buffer reaches the limit at the update event
      apb(1'b1, TFC_OFS_LIMIT_BUF, 32'h1234);
      chk(counter_limit, 32'hFFFF);
      rd_chk(TFC_OFS_STATUS, 32'h4);
      hw_update <= 1'b1;
      hw_count_load <= 1'b1;
      hw_count_value <= 16'h00AB;
      @(posedge clk);
      hw_update <= 1'b0;
      hw_count_load <= 1'b0;
      @(posedge clk);
      chk(counter_limit, 32'h1234);
      rd_chk(TFC_OFS_STATUS, 32'h0);
      rd_chk(TFC_OFS_COUNT, 32'hAB);
      // Channel 0 compare: overflow set, match clear, underflow toggle
      apb(1'b1, TFC_OFS_CH_CTRL, 32'h1E02);
      @(posedge clk);
      chk(pin_oe_n[0], 1'b1);
      apb(1'b1, TFC_OFS_ROUTE, 32'h7);
      rd_chk(TFC_OFS_ROUTE, 32'h7);
      chk(pin_oe_n[0], 1'b0);
      hw_overflow <= 1'b1;
      @(posedge clk);
      hw_overflow <= 1'b0;
      repeat (2) @(posedge clk);
      chk(pin_out[0], 1'b1);
      hw_match <= 3'b001;
      @(posedge clk);
      hw_match <= 3'b000;
      repeat (2) @(posedge clk);
      chk(pin_out[0], 1'b0);
      hw_underflow <= 1'b1;
      hw_capture_overrun <= 3'b100;
      @(posedge clk);
      hw_underflow <= 1'b0;
      hw_capture_overrun <= 3'b000;
      repeat (2) @(posedge clk);
      chk(pin_out[0], 1'b1);
      chk(flags[10], 1'b1);
      // Channel 1 capture edge and qualifier cases
      cap(32'h0000_0001, 1, 1);
      cap(32'h0100_0001, 2, 2);
      cap(32'h0200_0001, 1, 2);
      cap(32'h0A00_0001, 2, 2);
      cap(32'h0E00_0001, 2, 2);
      cap(32'h0400_0001, 2, 1);
      cap(32'h0020_0001, 1, 1);
      cap(32'h0015_0001, 1, 1);
      chk(flags[5], 1'b1);
      apb(1'b1, TFC_OFS_CH_CTRL + TFC_OFS_CH_STRIDE, 32'h0300_0001);
      ext_level[1] <= 1'b1;
      repeat (6) @(posedge clk);
      chk(ext_clock_in[1], 1'b1);
      final_report();
   end
endmodule : tfc_regs_tb_top
